// ### verilog/hwsg_pkg.sv
// package: command codes, register selects and condition bit positions
package hwsg_pkg;
   localparam int WIDTH = 16;
   // command codes on the decoded status command port
   typedef enum logic [2:0] {
      CMD_NONE = 3'b000,
      CMD_COND_QUERY = 3'b001,
      CMD_RISE_QUERY = 3'b010,
      CMD_FALL_QUERY = 3'b011,
      CMD_EVENT_QUERY = 3'b100,
      CMD_ENABLE_QUERY = 3'b101,
      CMD_WRITE = 3'b110,
      CMD_CLEAR_STATUS = 3'b111
   } hwsg_cmd_t;
   // register select for writes
   typedef enum logic [1:0] {
      SEL_RISE = 2'b00,
      SEL_FALL = 2'b01,
      SEL_ENABLE = 2'b10,
      SEL_NONE = 2'b11
   } hwsg_sel_t;
   localparam logic GRP_ONE = 1'b0;
   localparam logic GRP_TWO = 1'b1;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] ENABLE_RESET = 16'h0000;
   localparam logic [15:0] FILTER_RISE_RESET = 16'hffff;
   localparam logic [15:0] FILTER_FALL_RESET = 16'h0000;
   localparam logic [15:0] COND_TWO_MASK = 16'h7fff;
   localparam int BIT_RESERVED = 15;
   localparam int BIT_RIC_TWO = 14;
   localparam int BIT_RIC_ONE = 13;
   localparam int BIT_DEC_RESULTS = 12;
   localparam int BIT_DEC_LOW = 11;
   localparam int BIT_DEC_MEAS = 10;
   localparam int BIT_DEC_ARMED = 9;
   localparam int BIT_ENC_AUX = 8;
   localparam int BIT_ENC_INFO = 7;
   localparam int BIT_COMM_SUM = 6;
   localparam int BIT_LIMIT = 5;
   localparam int BIT_SELFTEST = 4;
   localparam int BIT_OVERPWR = 3;
   localparam int BIT_UNUSED = 2;
   localparam int BIT_MIKE = 1;
   localparam int BIT_BATT = 0;
endpackage

// ### verilog/hwsg_group.sv
// one status group: filters, latched events, enable and summary
`timescale 1ns/10ps
module hwsg_group #(
   parameter int W = 16
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic [W-1:0] cond,
   input wire logic wr_rise,
   input wire logic wr_fall,
   input wire logic wr_enable,
   input wire logic [W-1:0] wr_data,
   input wire logic event_clear,
   output logic [W-1:0] rise_q,
   output logic [W-1:0] fall_q,
   output logic [W-1:0] enable_q,
   output logic [W-1:0] event_q,
   output logic summary_d
);
   logic [W-1:0] cond_prev_q;
   logic [W-1:0] hit_d;

   // ***********************
   // filters and enable
   // ***********************
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rise_q <= W'(hwsg_pkg::FILTER_RISE_RESET);
         fall_q <= W'(hwsg_pkg::FILTER_FALL_RESET);
         enable_q <= W'(hwsg_pkg::ENABLE_RESET);
      end else if (clk_en) begin
         if (wr_rise) begin
            rise_q <= wr_data;
         end
         if (wr_fall) begin
            fall_q <= wr_data;
         end
         if (wr_enable) begin
            enable_q <= wr_data;
         end
      end
   end

   // ***********************
   // transition detect and event latch
   // ***********************
   assign hit_d = (cond & ~cond_prev_q & rise_q) | (~cond & cond_prev_q & fall_q);

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cond_prev_q <= W'(hwsg_pkg::REG_RESET);
         event_q <= W'(hwsg_pkg::REG_RESET);
      end else if (clk_en) begin
         cond_prev_q <= cond;
         // new hits win over a clear in the same cycle
         if (event_clear) begin
            event_q <= hit_d;
         end else begin
            event_q <= event_q | hit_d;
         end
      end
   end

   assign summary_d = |(event_q & enable_q);
endmodule

// ### verilog/hwsg_top.sv
// hardware status groups one and two with command access
`timescale 1ns/10ps
module hwsg_top #(
   parameter int W = 16
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic cmd_valid,
   input wire hwsg_pkg::hwsg_cmd_t cmd_code,
   input wire logic cmd_group,
   input wire hwsg_pkg::hwsg_sel_t cmd_sel,
   input wire logic [W-1:0] cmd_data,
   input wire logic ric_two_tripped,
   input wire logic ric_one_tripped,
   input wire logic dec_results,
   input wire logic dec_level_low,
   input wire logic dec_measuring,
   input wire logic dec_armed,
   input wire logic enc_two_fields,
   input wire logic enc_sending_one,
   input wire logic enc_sending_two,
   input wire logic enc_func_gen,
   input wire logic comm_summary,
   input wire logic meas_above_high,
   input wire logic meas_below_low,
   input wire logic selftest_failed,
   input wire logic overpower_tripped,
   input wire logic mike_keyed,
   input wire logic battery_low,
   input wire logic [W-1:0] group_two_cond,
   output logic rsp_valid,
   output logic [W-1:0] rsp_data,
   output logic summary_one,
   output logic summary_two
);
   logic [W-1:0] cond_one_d;
   logic [W-1:0] cond_two_d;
   logic enc_info_d;
   logic enc_aux_d;
   logic is_query_d;
   logic is_write_d;
   logic is_cls_d;
   logic [W-1:0] rise_one, fall_one, en_one, ev_one;
   logic [W-1:0] rise_two, fall_two, en_two, ev_two;
   logic sum_one_d;
   logic sum_two_d;
   logic [W-1:0] rsp_d;
   logic wr_rise_one, wr_fall_one, wr_en_one;
   logic wr_rise_two, wr_fall_two, wr_en_two;
   logic clr_one, clr_two;

   // ***********************
   // group one condition assembly
   // ***********************
   assign enc_aux_d = enc_two_fields & enc_sending_one & enc_sending_two;
   // single field, or exactly one of two, and never in function-generator setting
   assign enc_info_d = ~enc_func_gen & (enc_two_fields ?
      (enc_sending_one ^ enc_sending_two) : enc_sending_one);

   always_comb begin
      cond_one_d = '0;
      cond_one_d[hwsg_pkg::BIT_RESERVED] = 1'b0;
      cond_one_d[hwsg_pkg::BIT_RIC_TWO] = ric_two_tripped;
      cond_one_d[hwsg_pkg::BIT_RIC_ONE] = ric_one_tripped;
      cond_one_d[hwsg_pkg::BIT_DEC_RESULTS] = dec_results;
      cond_one_d[hwsg_pkg::BIT_DEC_LOW] = dec_level_low;
      cond_one_d[hwsg_pkg::BIT_DEC_MEAS] = dec_measuring;
      cond_one_d[hwsg_pkg::BIT_DEC_ARMED] = dec_armed;
      cond_one_d[hwsg_pkg::BIT_ENC_AUX] = enc_aux_d;
      cond_one_d[hwsg_pkg::BIT_ENC_INFO] = enc_info_d;
      cond_one_d[hwsg_pkg::BIT_COMM_SUM] = comm_summary;
      cond_one_d[hwsg_pkg::BIT_LIMIT] = meas_above_high | meas_below_low;
      cond_one_d[hwsg_pkg::BIT_SELFTEST] = selftest_failed;
      cond_one_d[hwsg_pkg::BIT_OVERPWR] = overpower_tripped;
      cond_one_d[hwsg_pkg::BIT_UNUSED] = 1'b0;
      cond_one_d[hwsg_pkg::BIT_MIKE] = mike_keyed;
      cond_one_d[hwsg_pkg::BIT_BATT] = battery_low;
   end

   assign cond_two_d = group_two_cond & W'(hwsg_pkg::COND_TWO_MASK);

   // ***********************
   // command decode
   // ***********************
   assign is_query_d = cmd_valid && (cmd_code == hwsg_pkg::CMD_COND_QUERY ||
      cmd_code == hwsg_pkg::CMD_RISE_QUERY || cmd_code == hwsg_pkg::CMD_FALL_QUERY ||
      cmd_code == hwsg_pkg::CMD_EVENT_QUERY || cmd_code == hwsg_pkg::CMD_ENABLE_QUERY);
   assign is_write_d = cmd_valid && cmd_code == hwsg_pkg::CMD_WRITE;
   assign is_cls_d = cmd_valid && cmd_code == hwsg_pkg::CMD_CLEAR_STATUS;

   assign wr_rise_one = is_write_d && cmd_group == hwsg_pkg::GRP_ONE &&
      cmd_sel == hwsg_pkg::SEL_RISE;
   assign wr_fall_one = is_write_d && cmd_group == hwsg_pkg::GRP_ONE &&
      cmd_sel == hwsg_pkg::SEL_FALL;
   assign wr_en_one = is_write_d && cmd_group == hwsg_pkg::GRP_ONE &&
      cmd_sel == hwsg_pkg::SEL_ENABLE;
   assign wr_rise_two = is_write_d && cmd_group == hwsg_pkg::GRP_TWO &&
      cmd_sel == hwsg_pkg::SEL_RISE;
   assign wr_fall_two = is_write_d && cmd_group == hwsg_pkg::GRP_TWO &&
      cmd_sel == hwsg_pkg::SEL_FALL;
   assign wr_en_two = is_write_d && cmd_group == hwsg_pkg::GRP_TWO &&
      cmd_sel == hwsg_pkg::SEL_ENABLE;

   // event query clears on the same edge that captures the old value into the answer
   assign clr_one = is_cls_d || (cmd_valid && cmd_code == hwsg_pkg::CMD_EVENT_QUERY &&
      cmd_group == hwsg_pkg::GRP_ONE);
   assign clr_two = is_cls_d || (cmd_valid && cmd_code == hwsg_pkg::CMD_EVENT_QUERY &&
      cmd_group == hwsg_pkg::GRP_TWO);

   // ***********************
   // the two groups
   // ***********************
   hwsg_group #(.W(W)) u_group_one (
      .mclk(mclk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .cond(cond_one_d),
      .wr_rise(wr_rise_one),
      .wr_fall(wr_fall_one),
      .wr_enable(wr_en_one),
      .wr_data(cmd_data),
      .event_clear(clr_one),
      .rise_q(rise_one),
      .fall_q(fall_one),
      .enable_q(en_one),
      .event_q(ev_one),
      .summary_d(sum_one_d)
   );

   hwsg_group #(.W(W)) u_group_two (
      .mclk(mclk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .cond(cond_two_d),
      .wr_rise(wr_rise_two),
      .wr_fall(wr_fall_two),
      .wr_enable(wr_en_two),
      .wr_data(cmd_data),
      .event_clear(clr_two),
      .rise_q(rise_two),
      .fall_q(fall_two),
      .enable_q(en_two),
      .event_q(ev_two),
      .summary_d(sum_two_d)
   );

   // ***********************
   // query answer mux
   // ***********************
   always_comb begin
      rsp_d = '0;
      case (cmd_code)
         hwsg_pkg::CMD_COND_QUERY: begin
            rsp_d = (cmd_group == hwsg_pkg::GRP_ONE) ? cond_one_d : cond_two_d;
         end
         hwsg_pkg::CMD_RISE_QUERY: begin
            rsp_d = (cmd_group == hwsg_pkg::GRP_ONE) ? rise_one : rise_two;
         end
         hwsg_pkg::CMD_FALL_QUERY: begin
            rsp_d = (cmd_group == hwsg_pkg::GRP_ONE) ? fall_one : fall_two;
         end
         hwsg_pkg::CMD_EVENT_QUERY: begin
            rsp_d = (cmd_group == hwsg_pkg::GRP_ONE) ? ev_one : ev_two;
         end
         hwsg_pkg::CMD_ENABLE_QUERY: begin
            rsp_d = (cmd_group == hwsg_pkg::GRP_ONE) ? en_one : en_two;
         end
         default: begin
            rsp_d = '0;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rsp_valid <= 1'b0;
         rsp_data <= W'(hwsg_pkg::REG_RESET);
      end else if (clk_en) begin
         rsp_valid <= is_query_d;
         if (is_query_d) begin
            rsp_data <= rsp_d;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         summary_one <= 1'b0;
         summary_two <= 1'b0;
      end else if (clk_en) begin
         summary_one <= sum_one_d;
         summary_two <= sum_two_d;
      end
   end

   // ***********************
   // checks
   // ***********************
   sequence s_event_query_one;
      cmd_valid && cmd_code == hwsg_pkg::CMD_EVENT_QUERY && cmd_group == hwsg_pkg::GRP_ONE
         && !is_cls_d && clk_en;
   endsequence

   a_event_query_answer: assert property (@(posedge mclk) disable iff (!reset_n)
      s_event_query_one |=> rsp_valid && rsp_data == $past(ev_one))
      else $error("event query answer wrong");

   a_event_query_clears: assert property (@(posedge mclk) disable iff (!reset_n)
      s_event_query_one |=> ev_one == $past(u_group_one.hit_d))
      else $error("event not cleared on query");

   a_cls_clears_two: assert property (@(posedge mclk) disable iff (!reset_n)
      is_cls_d && clk_en && $stable(cond_two_d) ##0 cond_two_d == u_group_two.cond_prev_q
      |=> ev_two == '0)
      else $error("clear status left events");

   a_reserved_zero: assert property (@(posedge mclk) disable iff (!reset_n)
      cmd_valid && clk_en && cmd_code == hwsg_pkg::CMD_COND_QUERY && cmd_group == hwsg_pkg::GRP_ONE
      |=> rsp_valid && !rsp_data[hwsg_pkg::BIT_RESERVED])
      else $error("reserved condition bit set");

   a_cond_answer: assert property (@(posedge mclk) disable iff (!reset_n)
      cmd_valid && clk_en && cmd_code == hwsg_pkg::CMD_COND_QUERY && cmd_group == hwsg_pkg::GRP_ONE
      |=> rsp_data == $past(cond_one_d))
      else $error("condition answer wrong");

   a_enable_write: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_en_two && clk_en |=> en_two == $past(cmd_data))
      else $error("enable write lost");

   a_info_fg_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
      enc_func_gen |-> !cond_one_d[hwsg_pkg::BIT_ENC_INFO])
      else $error("info bit active in generator mode");

   a_summary_follow: assert property (@(posedge mclk) disable iff (!reset_n)
      clk_en |=> summary_one == |($past(ev_one) & $past(en_one)))
      else $error("summary mismatch");

   a_event_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
      clk_en && !clr_one && ev_one[hwsg_pkg::BIT_BATT] |=> ev_one[hwsg_pkg::BIT_BATT])
      else $error("event bit dropped");
endmodule

// ### testbench/hwsg_ctrl_model.sv
// controller model: issues status commands and collects the answers
`timescale 1ns/10ps
module hwsg_ctrl_model (
   input wire logic mclk,
   input wire logic rsp_valid,
   input wire logic [15:0] rsp_data,
   output logic cmd_valid,
   output hwsg_pkg::hwsg_cmd_t cmd_code,
   output logic cmd_group,
   output hwsg_pkg::hwsg_sel_t cmd_sel,
   output logic [15:0] cmd_data
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = hwsg_pkg::CMD_NONE;
      cmd_group = 1'b0;
      cmd_sel = hwsg_pkg::SEL_NONE;
      cmd_data = 16'h0000;
   end
   // ***************************************
   // one command, held across its taking edge
   // ***************************************
   task automatic send(input hwsg_pkg::hwsg_cmd_t c, input logic g,
         input hwsg_pkg::hwsg_sel_t s, input logic [15:0] d);
      @(posedge mclk);
      #1;
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_group = g;
      cmd_sel = s;
      cmd_data = d;
      @(posedge mclk);
      #1;
      cmd_valid = 1'b0;
      cmd_data = ~d;
   endtask
   // answer stands in the cycle after the taking edge
   task automatic query(input hwsg_pkg::hwsg_cmd_t c, input logic g,
         output logic [15:0] r, output logic ok);
      send(c, g, hwsg_pkg::SEL_NONE, 16'h0000);
      ok = (rsp_valid === 1'b1);
      r = rsp_data;
   endtask
endmodule

// ### testbench/hwsg_top_tb.sv
// self-checking bench for the hardware status groups
`timescale 1ns/10ps
module hwsg_top_tb;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic [16:0] src = 17'h00000;
   logic [15:0] g2 = 16'h0000;
   logic cmd_valid, cmd_group, rsp_valid, summary_one, summary_two;
   hwsg_pkg::hwsg_cmd_t cmd_code;
   hwsg_pkg::hwsg_sel_t cmd_sel;
   logic [15:0] cmd_data, rsp_data;
   int error_cnt = 0;
   int num_checks = 0;
   logic [16:0] enc_vec [5] = '{17'h00700, 17'h00600, 17'h00500, 17'h00280, 17'h00680};
   always #50 mclk = ~mclk;
   hwsg_top u_hwsg_top (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_group(cmd_group),
      .cmd_sel(cmd_sel), .cmd_data(cmd_data), .ric_two_tripped(src[16]),
      .ric_one_tripped(src[15]), .dec_results(src[14]), .dec_level_low(src[13]),
      .dec_measuring(src[12]), .dec_armed(src[11]), .enc_two_fields(src[10]),
      .enc_sending_one(src[9]), .enc_sending_two(src[8]), .enc_func_gen(src[7]),
      .comm_summary(src[6]), .meas_above_high(src[5]), .meas_below_low(src[4]),
      .selftest_failed(src[3]), .overpower_tripped(src[2]), .mike_keyed(src[1]),
      .battery_low(src[0]), .group_two_cond(g2), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .summary_one(summary_one), .summary_two(summary_two));
   hwsg_ctrl_model u_hwsg_ctrl_model (.mclk(mclk), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_group(cmd_group), .cmd_sel(cmd_sel), .cmd_data(cmd_data));
   // ***************************************
   // helpers
   // ***************************************
   function automatic logic [15:0] exp_cond(input logic [16:0] s);
      logic [15:0] e;
      e = 16'h0000;
      e[14:9] = s[16:11];
      e[8] = s[10] & s[9] & s[8];
      e[7] = ~s[7] & (s[10] ? (s[9] ^ s[8]) : s[9]);
      e[6] = s[6];
      e[5] = s[5] | s[4];
      e[4:3] = s[3:2];
      e[1:0] = s[1:0];
      return e;
   endfunction
   task automatic close_out();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic qc(input string n, input hwsg_pkg::hwsg_cmd_t c, input logic g,
         input logic [15:0] e);
      logic [15:0] r;
      logic ok;
      u_hwsg_ctrl_model.query(c, g, r, ok);
      chk("rsp_valid", 16'h0001, {15'h0000, ok});
      chk(n, e, r);
   endtask
   task automatic wr(input hwsg_pkg::hwsg_sel_t s, input logic g, input logic [15:0] d);
      u_hwsg_ctrl_model.send(hwsg_pkg::CMD_WRITE, g, s, d);
   endtask
   task automatic cls();
      u_hwsg_ctrl_model.send(hwsg_pkg::CMD_CLEAR_STATUS, 1'b0, hwsg_pkg::SEL_NONE, 16'h0000);
   endtask
   task automatic step(input logic [16:0] v);
      src = v;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic wait_sum(input logic w, input logic e);
      logic s;
      s = ~e;
      for (int k = 0; k < 8 && s !== e; k++) begin
         @(posedge mclk);
         #1;
         s = w ? summary_two : summary_one;
      end
      chk("summary", {15'h0000, e}, {15'h0000, s});
      if (s !== e) close_out();
   endtask
   initial begin
      #3000000;
      error_cnt++;
      close_out();
   end
   // ***************************************
   // main sequence
   // ***************************************
   initial begin
      repeat (12) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      for (int g = 0; g < 2; g++) begin
         qc("rise", hwsg_pkg::CMD_RISE_QUERY, g[0], 16'hffff);
         qc("fall", hwsg_pkg::CMD_FALL_QUERY, g[0], 16'h0000);
         qc("enable", hwsg_pkg::CMD_ENABLE_QUERY, g[0], 16'h0000);
         qc("event", hwsg_pkg::CMD_EVENT_QUERY, g[0], 16'h0000);
      end
      for (int i = 0; i < 17; i++) begin
         if (i != 8) begin
            src = 17'h00001 << i;
            qc("cond_one", hwsg_pkg::CMD_COND_QUERY, 1'b0, exp_cond(src));
         end
      end
      foreach (enc_vec[i]) begin
         src = enc_vec[i];
         qc("cond_enc", hwsg_pkg::CMD_COND_QUERY, 1'b0, exp_cond(src));
      end
      qc("cond_again", hwsg_pkg::CMD_COND_QUERY, 1'b0, exp_cond(src));
      g2 = 16'hffff;
      qc("cond_two", hwsg_pkg::CMD_COND_QUERY, 1'b1, 16'h7fff);
      step(17'h00000);
      g2 = 16'h0000;
      cls();
      qc("event_one", hwsg_pkg::CMD_EVENT_QUERY, 1'b0, 16'h0000);
      qc("event_two", hwsg_pkg::CMD_EVENT_QUERY, 1'b1, 16'h0000);
      wr(hwsg_pkg::SEL_RISE, 1'b0, 16'h0001);
      wr(hwsg_pkg::SEL_FALL, 1'b0, 16'h0002);
      wr(hwsg_pkg::SEL_ENABLE, 1'b0, 16'h0003);
      wr(hwsg_pkg::SEL_NONE, 1'b0, 16'h1234);
      qc("rise", hwsg_pkg::CMD_RISE_QUERY, 1'b0, 16'h0001);
      qc("fall", hwsg_pkg::CMD_FALL_QUERY, 1'b0, 16'h0002);
      qc("enable", hwsg_pkg::CMD_ENABLE_QUERY, 1'b0, 16'h0003);
      step(17'h00001);
      wait_sum(1'b0, 1'b1);
      step(17'h00000);
      step(17'h00002);
      step(17'h00000);
      qc("event_one", hwsg_pkg::CMD_EVENT_QUERY, 1'b0, 16'h0003);
      qc("event_one", hwsg_pkg::CMD_EVENT_QUERY, 1'b0, 16'h0000);
      wait_sum(1'b0, 1'b0);
      step(17'h00001);
      wait_sum(1'b0, 1'b1);
      wr(hwsg_pkg::SEL_ENABLE, 1'b0, 16'h0000);
      wait_sum(1'b0, 1'b0);
      qc("event_one", hwsg_pkg::CMD_EVENT_QUERY, 1'b0, 16'h0001);
      step(17'h00000);
      step(17'h00001);
      g2 = 16'h0008;
      wr(hwsg_pkg::SEL_ENABLE, 1'b1, 16'h0008);
      wait_sum(1'b1, 1'b1);
      cls();
      qc("event_two", hwsg_pkg::CMD_EVENT_QUERY, 1'b1, 16'h0000);
      qc("event_one", hwsg_pkg::CMD_EVENT_QUERY, 1'b0, 16'h0000);
      wait_sum(1'b1, 1'b0);
      clk_en = 1'b0;
      wr(hwsg_pkg::SEL_ENABLE, 1'b0, 16'h00ff);
      clk_en = 1'b1;
      qc("enable", hwsg_pkg::CMD_ENABLE_QUERY, 1'b0, 16'h0000);
      wr(hwsg_pkg::SEL_RISE, 1'b1, 16'h0f0f);
      wr(hwsg_pkg::SEL_FALL, 1'b1, 16'h5a5a);
      qc("rise_two", hwsg_pkg::CMD_RISE_QUERY, 1'b1, 16'h0f0f);
      qc("fall_two", hwsg_pkg::CMD_FALL_QUERY, 1'b1, 16'h5a5a);
      close_out();
   end
endmodule
